// >>> common/cbh_pkg.sv
// constants and types shared by the bus cycle and hold unit
package cbh_pkg;

    // ************************
    // widths
    // ************************
    localparam int CBH_ADDR_W = 23;
    localparam int CBH_DATA_W = 16;

    // ************************
    // cycle definition {mem_io, data_ctl, write_read}
    // ************************
    localparam logic [2:0] CBH_CYC_INTA = 3'h0;
    localparam logic [2:0] CBH_CYC_NEVER = 3'h1;
    localparam logic [2:0] CBH_CYC_IO_RD = 3'h2;
    localparam logic [2:0] CBH_CYC_IO_WR = 3'h3;
    localparam logic [2:0] CBH_CYC_CODE = 3'h4;
    localparam logic [2:0] CBH_CYC_HALT = 3'h5;
    localparam logic [2:0] CBH_CYC_MEM_RD = 3'h6;
    localparam logic [2:0] CBH_CYC_MEM_WR = 3'h7;

    // ************************
    // byte enables {upper_n, lower_n}
    // ************************
    localparam logic [1:0] CBH_BE_WORD = 2'h0;
    localparam logic [1:0] CBH_BE_UPPER = 2'h1;
    localparam logic [1:0] CBH_BE_LOWER = 2'h2;
    localparam logic [1:0] CBH_BE_NONE = 2'h3;

    // ************************
    // special cycle addresses, word address bits addr_out
    // ************************
    localparam logic [22:0] CBH_HALT_ADDR = 23'h00_0001;
    localparam logic [22:0] CBH_SHUT_ADDR = 23'h00_0000;

    // ************************
    // reset values
    // ************************
    localparam logic [2:0] CBH_RST_CYC = CBH_CYC_CODE;
    localparam logic [1:0] CBH_RST_BE = CBH_BE_WORD;
    localparam logic [22:0] CBH_RST_ADDR = 23'h00_0000;
    localparam logic [15:0] CBH_RST_DATA = 16'h0000;
    // sync reset pattern {nmi, hold, na_n, ready_n, data}
    localparam logic [19:0] CBH_SYNC_RST = 20'h3_0000;

    typedef enum logic [2:0] {
        CBH_S_IDLE = 3'b000,
        CBH_S_T1 = 3'b001,
        CBH_S_T2 = 3'b010,
        CBH_S_FLOAT = 3'b011,
        CBH_S_HOLD = 3'b100
    } cbh_state_type;

endpackage

// >>> core/cbh_pin_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module cbh_pin_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // pins in, synchronised out
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    if (W < 1)
    begin : g_chk
        $error("cbh_pin_sync: width must be at least one");
    end

    always_comb
    begin
        meta_nxt = pin_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;
endmodule
`default_nettype wire

// >>> core/cbh_bus_unit.sv
// local bus cycle, pipelining and hold unit
// Operation
// - cycle type coded on three definition outputs; code 001 never driven
// - halt puts address 2, shutdown address 0, upper enable off, lower on
// - byte enables: word 00, upper 01, lower 10, never 11
// - definition valid with strobe; lock valid only when cycle begins
// - lock asserts at first locked cycle begin, releases on final ready
// - cycle begins on ready with strobe pending, or strobe from idle
// - lock for locked instructions, exchange, descriptor updates, interrupt acknowledge
// - strobe only with valid address and definition, held stable meanwhile
// - pipelined strobe stays active until previous cycle gets ready
// - ready latches read data for reads and acknowledges, ends writes
// - ready ignored in first bus state, sampled after, wait states meanwhile
// - next-address request with pending request drives next cycle early
// - next-address request ignored when strobe or ready activates
// - on hold grant float bus first, then raise acknowledge
// - hold negated: drop acknowledge and drive bus in same clock
// - hold ignored during reset; reset leaves bus idle and driven
// - one interrupt edge remembered during hold, delivered after release
// - hold granted only after the current bus operation ends
// - split transfers internally locked; hold deferred, lock pin untouched
// - input clock divided by two; each input period one phase
// - cycle lasts at least two internal clocks, more without ready
`timescale 1ns/1ps
`default_nettype none
module cbh_bus_unit
    import cbh_pkg::*;
#(
    parameter int ADDR_W = CBH_ADDR_W,
    parameter int DATA_W = CBH_DATA_W
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // internal bus requests
    input wire logic req_valid_i,
    input wire logic [2:0] req_cyc_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [1:0] req_be_n_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    input wire logic req_lock_i,
    input wire logic req_split_more_i,
    input wire logic req_shutdown_i,
    output logic req_ready_o,
    // completion
    output logic [DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic cyc_done_o,
    // interrupt edge
    input wire logic nmi_i,
    output logic nmi_req_o,
    // bus pins
    output logic [ADDR_W-1:0] addr_out_o,
    output logic upper_byte_en_n_o,
    output logic lower_byte_en_n_o,
    output logic mem_io_o,
    output logic data_ctl_o,
    output logic write_read_o,
    output logic lock_n_o,
    output logic address_strobe_n_o,
    output logic bus_oe_o,
    input wire logic [DATA_W-1:0] data_io_i,
    output logic [DATA_W-1:0] data_io_o,
    output logic data_io_oe_o,
    input wire logic ready_n_i,
    input wire logic next_address_req_n_i,
    input wire logic hold_i,
    output logic bus_grant_ack_o
);
    if (ADDR_W != CBH_ADDR_W || DATA_W != CBH_DATA_W)
    begin : g_chk
        $error("cbh_bus_unit: only 23 address and 16 data bits are served");
    end

    function automatic logic cbh_is_write(input logic [2:0] c);
        cbh_is_write = (c == CBH_CYC_IO_WR) || (c == CBH_CYC_MEM_WR);
    endfunction

    function automatic logic cbh_is_locked(input logic [2:0] c, input logic l);
        cbh_is_locked = l || (c == CBH_CYC_INTA);
    endfunction

    // ************************
    // pin synchronisers
    // ************************
    logic [19:0] syn;
    cbh_pin_sync #(.W(20), .RST_VAL(CBH_SYNC_RST)) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pin_i({nmi_i, hold_i, next_address_req_n_i, ready_n_i, data_io_i}),
        .sync_o(syn)
    );
    logic nmi_s;
    logic hold_s;
    logic na_s;
    logic ready_s;
    logic [DATA_W-1:0] din_s;
    assign nmi_s = syn[19];
    assign hold_s = syn[18];
    assign na_s = !syn[17];
    assign ready_s = !syn[16];
    assign din_s = syn[15:0];

    // ************************
    // bus state group
    // ************************
    cbh_state_type state_r, state_nxt;
    logic ph_r, ph_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [1:0] be_r, be_nxt;
    logic [2:0] cyc_r, cyc_nxt;
    logic ads_n_r, ads_n_nxt;
    logic lock_n_r, lock_n_nxt;
    logic oe_r, oe_nxt;
    logic ack_r, ack_nxt;
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic doe_r, doe_nxt;
    logic [2:0] cur_cyc_r, cur_cyc_nxt;
    logic pipe_r, pipe_nxt;
    logic pipe_lock_r, pipe_lock_nxt;
    logic [DATA_W-1:0] pipe_data_r, pipe_data_nxt;
    logic split_r, split_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic done_r, done_nxt;
    logic take;
    logic can_issue;
    logic hold_ok;
    logic [ADDR_W-1:0] eff_addr;
    logic [1:0] eff_be;
    logic req_lk;

    always_comb
    begin
        can_issue = req_valid_i && (req_cyc_i != CBH_CYC_NEVER);
        hold_ok = hold_s && !split_r && lock_n_r;
        req_lk = cbh_is_locked(req_cyc_i, req_lock_i);
        if (req_cyc_i == CBH_CYC_HALT)
        begin
            eff_addr = req_shutdown_i ? CBH_SHUT_ADDR : CBH_HALT_ADDR;
            eff_be = CBH_BE_LOWER;
        end
        else
        begin
            eff_addr = req_addr_i;
            // both-off request folded to a word
            eff_be = (req_be_n_i == CBH_BE_NONE) ? CBH_BE_WORD : req_be_n_i;
        end
        // one bus state per two input clocks
        ph_nxt = !ph_r;
        state_nxt = state_r;
        addr_nxt = addr_r;
        be_nxt = be_r;
        cyc_nxt = cyc_r;
        ads_n_nxt = ads_n_r;
        lock_n_nxt = lock_n_r;
        oe_nxt = oe_r;
        ack_nxt = ack_r;
        dout_nxt = dout_r;
        doe_nxt = doe_r;
        cur_cyc_nxt = cur_cyc_r;
        pipe_nxt = pipe_r;
        pipe_lock_nxt = pipe_lock_r;
        pipe_data_nxt = pipe_data_r;
        split_nxt = split_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        done_nxt = 1'b0;
        take = 1'b0;
        unique case (state_r)
            CBH_S_IDLE:
            begin
                if (ph_r && hold_ok)
                begin
                    state_nxt = CBH_S_FLOAT;
                    oe_nxt = 1'b0;
                    doe_nxt = 1'b0;
                end
                else if (ph_r && can_issue)
                begin
                    // strobe with address and definition together
                    take = 1'b1;
                    state_nxt = CBH_S_T1;
                    ads_n_nxt = 1'b0;
                    addr_nxt = eff_addr;
                    be_nxt = eff_be;
                    cyc_nxt = req_cyc_i;
                    cur_cyc_nxt = req_cyc_i;
                    dout_nxt = req_wdata_i;
                    doe_nxt = cbh_is_write(req_cyc_i);
                    split_nxt = req_split_more_i;
                    // cycle begins on strobe from idle
                    lock_n_nxt = !req_lk;
                end
            end
            CBH_S_T1:
            begin
                // ready not looked at in the first state
                if (ph_r)
                begin
                    state_nxt = CBH_S_T2;
                    ads_n_nxt = 1'b1;
                end
            end
            CBH_S_T2:
            begin
                if (ph_r && ready_s)
                begin
                    // latch read data, end the cycle
                    done_nxt = 1'b1;
                    if (!cbh_is_write(cur_cyc_r) && cur_cyc_r != CBH_CYC_HALT)
                    begin
                        rdata_nxt = din_s;
                        rvalid_nxt = 1'b1;
                    end
                    ads_n_nxt = 1'b1;
                    if (pipe_r)
                    begin
                        // pending strobe ends as its cycle begins
                        state_nxt = CBH_S_T1;
                        pipe_nxt = 1'b0;
                        cur_cyc_nxt = cyc_r;
                        dout_nxt = pipe_data_r;
                        doe_nxt = cbh_is_write(cyc_r);
                        // lock settles at the begin, not the strobe
                        lock_n_nxt = !pipe_lock_r;
                    end
                    else
                    begin
                        state_nxt = CBH_S_IDLE;
                        doe_nxt = 1'b0;
                        // release unless the next one is locked too
                        lock_n_nxt = lock_n_r || !(can_issue && req_lk);
                    end
                end
                else if (ph_r && na_s && !pipe_r && can_issue && !hold_ok)
                begin
                    // next address out before this cycle ends
                    take = 1'b1;
                    pipe_nxt = 1'b1;
                    ads_n_nxt = 1'b0;
                    addr_nxt = eff_addr;
                    be_nxt = eff_be;
                    cyc_nxt = req_cyc_i;
                    pipe_data_nxt = req_wdata_i;
                    pipe_lock_nxt = req_lk;
                    split_nxt = req_split_more_i;
                end
            end
            CBH_S_FLOAT:
            begin
                if (ph_r)
                begin
                    state_nxt = CBH_S_HOLD;
                    ack_nxt = 1'b1;
                end
            end
            CBH_S_HOLD:
            begin
                // acknowledge off and bus driven together
                if (ph_r && !hold_s)
                begin
                    state_nxt = CBH_S_IDLE;
                    ack_nxt = 1'b0;
                    oe_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = CBH_S_IDLE;
            end
        endcase
    end

    // reset wins over hold: idle, driven bus
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_r <= CBH_S_IDLE;
            ph_r <= 1'b0;
            addr_r <= CBH_RST_ADDR;
            be_r <= CBH_RST_BE;
            cyc_r <= CBH_RST_CYC;
            ads_n_r <= 1'b1;
            lock_n_r <= 1'b1;
            oe_r <= 1'b1;
            ack_r <= 1'b0;
            dout_r <= CBH_RST_DATA;
            doe_r <= 1'b0;
            cur_cyc_r <= CBH_RST_CYC;
            pipe_r <= 1'b0;
            pipe_lock_r <= 1'b0;
            pipe_data_r <= CBH_RST_DATA;
            split_r <= 1'b0;
            rdata_r <= CBH_RST_DATA;
            rvalid_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ph_r <= ph_nxt;
            addr_r <= addr_nxt;
            be_r <= be_nxt;
            cyc_r <= cyc_nxt;
            ads_n_r <= ads_n_nxt;
            lock_n_r <= lock_n_nxt;
            oe_r <= oe_nxt;
            ack_r <= ack_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            cur_cyc_r <= cur_cyc_nxt;
            pipe_r <= pipe_nxt;
            pipe_lock_r <= pipe_lock_nxt;
            pipe_data_r <= pipe_data_nxt;
            split_r <= split_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            done_r <= done_nxt;
        end
    end

    // ************************
    // interrupt edge group
    // ************************
    logic nmi_prev_r, nmi_prev_nxt;
    logic nmi_mem_r, nmi_mem_nxt;
    logic nmi_req_r, nmi_req_nxt;
    logic in_hold;

    always_comb
    begin
        // float phase counts as hold so no edge slips out mid-handover
        in_hold = (state_r == CBH_S_FLOAT) || (state_r == CBH_S_HOLD);
        nmi_prev_nxt = nmi_s;
        nmi_mem_nxt = nmi_mem_r;
        nmi_req_nxt = 1'b0;
        if (in_hold)
        begin
            if (nmi_s && !nmi_prev_r)
            begin
                nmi_mem_nxt = 1'b1;
            end
        end
        else if (nmi_mem_r || (nmi_s && !nmi_prev_r))
        begin
            nmi_req_nxt = 1'b1;
            nmi_mem_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            nmi_prev_r <= 1'b0;
            nmi_mem_r <= 1'b0;
            nmi_req_r <= 1'b0;
        end
        else
        begin
            nmi_prev_r <= nmi_prev_nxt;
            nmi_mem_r <= nmi_mem_nxt;
            nmi_req_r <= nmi_req_nxt;
        end
    end

    // ************************
    // outputs
    // ************************
    assign req_ready_o = take;
    assign rd_data_o = rdata_r;
    assign rd_valid_o = rvalid_r;
    assign cyc_done_o = done_r;
    assign nmi_req_o = nmi_req_r;
    assign addr_out_o = addr_r;
    assign upper_byte_en_n_o = be_r[1];
    assign lower_byte_en_n_o = be_r[0];
    assign mem_io_o = cyc_r[2];
    assign data_ctl_o = cyc_r[1];
    assign write_read_o = cyc_r[0];
    assign lock_n_o = lock_n_r;
    assign address_strobe_n_o = ads_n_r;
    assign bus_oe_o = oe_r;
    assign data_io_o = dout_r;
    assign data_io_oe_o = doe_r;
    assign bus_grant_ack_o = ack_r;

    // ************************
    // checks
    // ************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_no_code_one: assert property (!ads_n_r |-> cyc_r != CBH_CYC_NEVER)
        else $error("unused cycle code on bus");
    chk_halt_addr: assert property ((!ads_n_r && cyc_r == CBH_CYC_HALT) |->
        (be_r == CBH_BE_LOWER && (addr_r == CBH_HALT_ADDR || addr_r == CBH_SHUT_ADDR)))
        else $error("halt cycle address or enables wrong");
    chk_be_never: assert property (oe_r |-> be_r != CBH_BE_NONE)
        else $error("both byte enables off");
    chk_ads_stable: assert property ((!ads_n_r && $past(!ads_n_r)) |->
        ($stable(addr_r) && $stable(be_r) && $stable(cyc_r)))
        else $error("pins moved under active strobe");
    chk_pipe_held: assert property (pipe_r && !ads_n_r && !(ph_r && ready_s) |=> !ads_n_r)
        else $error("pipelined strobe dropped early");
    chk_done_from_t2: assert property (done_r |-> $past(state_r) == CBH_S_T2)
        else $error("cycle ended outside second state");
    chk_t1_length: assert property ((state_r == CBH_S_T1 && $changed(state_r)) |=>
        state_r == CBH_S_T1 ##1 state_r != CBH_S_T1)
        else $error("first bus state not one internal clock");
    chk_lock_release: assert property ($rose(lock_n_r) |-> $past(state_r) == CBH_S_T2)
        else $error("lock released outside ready");
    chk_na_at_ready: assert property (state_r == CBH_S_T2 && ph_r && ready_s |=> ads_n_r)
        else $error("next address taken in ready cycle");
    chk_float_first: assert property ($rose(ack_r) |-> !oe_r && !doe_r && $past(!oe_r, 2))
        else $error("acknowledge before bus floated");
    chk_drive_on_release: assert property ($fell(ack_r) |-> oe_r)
        else $error("bus not driven when acknowledge falls");
    chk_no_hold_in_cycle: assert property (state_r == CBH_S_T2 |=> state_r != CBH_S_FLOAT)
        else $error("hold taken inside a bus cycle");
    chk_nmi_deferred: assert property (ack_r |=> !nmi_req_r)
        else $error("interrupt delivered during hold");

    cov_pipelined: cover property (pipe_r && ph_r && ready_s && state_r == CBH_S_T2);
    cov_hold: cover property ($rose(ack_r));
    cov_wait: cover property (state_r == CBH_S_T2 && ph_r && !ready_s ##2 ph_r && ready_s);
endmodule
`default_nettype wire

// >>> bench/cbh_far_model.sv
// far side model: decode logic returning ready and read data, plus a hold master
`timescale 1ns/1ps
`default_nettype none
module cbh_far_model
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // bus pins from the unit
    input wire logic [22:0] addr_i,
    input wire logic strobe_n_i,
    input wire logic bus_oe_i,
    input wire logic [15:0] dout_i,
    input wire logic dout_oe_i,
    // knobs from the bench
    input wire logic [3:0] wait_i,
    input wire logic na_en_i,
    input wire logic hold_req_i,
    // pins back to the unit
    output logic ready_n_o,
    output logic [15:0] din_o,
    output logic na_n_o,
    output logic hold_o
);
    // ****************
    // ready engine
    // ****************
    logic [22:0] aq[$];
    logic [15:0] rd_r;
    logic prev_r;
    int ph_r;
    int t_r;
    initial {ready_n_o, na_n_o, hold_o, rd_r} = 19'h6_0000;
    // released data wire shows the inverse of the last value, never a stale copy
    assign din_o = dout_oe_i ? dout_i : rd_r;
    always @(posedge clk_i)
        hold_o <= hold_req_i;
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            {ready_n_o, na_n_o, prev_r} <= 3'h7;
            ph_r <= 0;
            t_r <= 0;
            aq.delete();
        end
        else
        begin
            na_n_o <= !na_en_i;
            prev_r <= strobe_n_i | !bus_oe_i;
            if (bus_oe_i && !strobe_n_i && prev_r)
                aq.push_back(addr_i);
            t_r <= t_r + 1;
            if (ph_r == 0 && aq.size() > 0)
            begin
                ph_r <= 1;
                t_r <= 0;
            end
            else if (ph_r == 1 && t_r >= 2 + int'(wait_i))
            begin
                ph_r <= 2;
                t_r <= 0;
                ready_n_o <= 1'b0;
                rd_r <= aq[0][15:0] ^ 16'ha5a5;
            end
            else if (ph_r == 2 && t_r == 1)
            begin
                ph_r <= 3;
                t_r <= 0;
                ready_n_o <= 1'b1;
                rd_r <= ~rd_r;
                void'(aq.pop_front());
            end
            else if (ph_r == 3 && t_r == 1)
                ph_r <= 0;
        end
    end
endmodule
`default_nettype wire

// >>> bench/cbh_bus_unit_tb.sv
// self-checking bench for the bus cycle and hold unit
`timescale 1ns/1ps
`default_nettype none
module cbh_bus_unit_tb import cbh_pkg::*;;
    // ****************
    // stimulus and scoreboard
    // ****************
    typedef struct packed {
        logic [2:0] cyc;
        logic [22:0] addr;
        logic [1:0] be;
        logic lk;
        logic [15:0] wd;
    } cbh_note_type;
    logic clk_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, req_lock_i = 1'b0;
    logic req_split_more_i = 1'b0, req_shutdown_i = 1'b0, nmi_i = 1'b0;
    logic [2:0] req_cyc_i = CBH_CYC_CODE;
    logic [22:0] req_addr_i = '0, addr_out_o;
    logic [1:0] req_be_n_i = '0;
    logic [15:0] req_wdata_i = '0, rd_data_o, data_io_i, data_io_o, wd_r;
    logic [3:0] wait_n = '0;
    logic na_en = 1'b0, hold_req = 1'b0, lk_r, taken, sp = 1'b1, rp = 1'b1, oe_p = 1'b1;
    logic req_ready_o, rd_valid_o, cyc_done_o, nmi_req_o, upper_byte_en_n_o, lower_byte_en_n_o;
    logic mem_io_o, data_ctl_o, write_read_o, lock_n_o, address_strobe_n_o, bus_oe_o;
    logic data_io_oe_o, ready_n_i, next_address_req_n_i, hold_i, bus_grant_ack_o;
    cbh_note_type nq[$], n_m;
    logic [27:0] pq[$], p_m;
    int t0[$];
    logic [31:0] rs = 32'h1d38_7113;
    int fail_count = 0, samples_checked = 0, cyc_n = 0, dones = 0, nmis = 0, piped = 0, i;
    logic [2:0] codes [7] = '{CBH_CYC_INTA, CBH_CYC_IO_RD, CBH_CYC_IO_WR, CBH_CYC_CODE,
        CBH_CYC_HALT, CBH_CYC_MEM_RD, CBH_CYC_MEM_WR};
    logic [1:0] bes [3] = '{CBH_BE_WORD, CBH_BE_UPPER, CBH_BE_LOWER};
    wire logic [27:0] pins = {mem_io_o, data_ctl_o, write_read_o, addr_out_o,
        upper_byte_en_n_o, lower_byte_en_n_o};

    cbh_bus_unit dut (.clk_i, .rst_b_i, .req_valid_i, .req_cyc_i, .req_addr_i, .req_be_n_i,
        .req_wdata_i, .req_lock_i, .req_split_more_i, .req_shutdown_i, .req_ready_o, .rd_data_o,
        .rd_valid_o, .cyc_done_o, .nmi_i, .nmi_req_o, .addr_out_o, .upper_byte_en_n_o,
        .lower_byte_en_n_o, .mem_io_o, .data_ctl_o, .write_read_o, .lock_n_o,
        .address_strobe_n_o, .bus_oe_o, .data_io_i, .data_io_o, .data_io_oe_o, .ready_n_i,
        .next_address_req_n_i, .hold_i, .bus_grant_ack_o);
    cbh_far_model far (.clk_i, .rst_b_i, .addr_i(addr_out_o), .strobe_n_i(address_strobe_n_o),
        .bus_oe_i(bus_oe_o), .dout_i(data_io_o), .dout_oe_i(data_io_oe_o), .wait_i(wait_n),
        .na_en_i(na_en), .hold_req_i(hold_req), .ready_n_o(ready_n_i), .din_o(data_io_i),
        .na_n_o(next_address_req_n_i), .hold_o(hold_i));

    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i)
        taken <= req_valid_i & req_ready_o;

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic stop(input string w);
        chk(0, 1, w);
        final_report();
    endtask

    task automatic send(input logic [2:0] c, input logic [22:0] a, input logic [1:0] b,
        input logic lk, input logic sm, input logic sh);
        cbh_note_type n;
        int k;
        n.cyc = c;
        n.addr = (c == CBH_CYC_HALT) ? (sh ? CBH_SHUT_ADDR : CBH_HALT_ADDR) : a;
        n.be = (c == CBH_CYC_HALT) ? CBH_BE_LOWER : b;
        n.lk = lk | (c == CBH_CYC_INTA);
        n.wd = 16'(rnd());
        req_cyc_i = c;
        req_addr_i = a;
        req_be_n_i = b;
        req_wdata_i = n.wd;
        req_lock_i = lk;
        req_split_more_i = sm;
        req_shutdown_i = sh;
        req_valid_i = 1'b1;
        k = 0;
        do
        begin
            @(negedge clk_i);
            k++;
        end
        while (taken !== 1'b1 && k < 200);
        if (taken !== 1'b1)
            stop("request not taken");
        nq.push_back(n);
    endtask

    task automatic wait_until(input logic ack, input logic empty);
        int k;
        for (k = 0; k < 400 && (empty ? nq.size() > 0 : bus_grant_ack_o !== ack); k++)
            @(negedge clk_i);
        if (empty ? nq.size() > 0 : bus_grant_ack_o !== ack)
            stop("wait ran out");
    endtask

    // done handled before strobe so a same-edge restart is not counted as overlap
    always @(negedge clk_i)
    begin
        cyc_n++;
        if (cyc_done_o === 1'b1)
        begin
            dones++;
            if (nq.size() == 0 || pq.size() == 0)
                stop("stray done");
            n_m = nq.pop_front();
            p_m = pq.pop_front();
            chk(p_m, {n_m.cyc, n_m.addr, n_m.be}, "cycle pins");
            chk(lk_r, !n_m.lk, "lock pin");
            chk(cyc_n - t0.pop_front() >= 4, 1, "cycle too short");
            // write_read low means data comes in; halt reads nothing
            chk(rd_valid_o, !n_m.cyc[0], "read strobe");
            if (!n_m.cyc[0])
                chk(rd_data_o, n_m.addr[15:0] ^ 16'ha5a5, "read data");
            if (n_m.cyc[1:0] == 2'b11)
                chk(wd_r, n_m.wd, "write data");
        end
        chk(bus_grant_ack_o & (bus_oe_o | data_io_oe_o | oe_p), 0, "driven in hold");
        oe_p = bus_oe_o;
        if (bus_oe_o && !address_strobe_n_o && sp)
        begin
            piped += (pq.size() > 0);
            pq.push_back(pins);
            t0.push_back(cyc_n);
        end
        else if (bus_oe_o && !address_strobe_n_o && pq.size() > 0)
            chk(pins, pq[$], "pins moved");
        sp = address_strobe_n_o | !bus_oe_o;
        if (!ready_n_i && rp)
        begin
            lk_r = lock_n_o;
            wd_r = data_io_oe_o ? data_io_o : 16'hxxxx;
        end
        rp = ready_n_i;
        nmis += (nmi_req_o === 1'b1);
    end

    initial
    begin
        hold_req = 1'b1;
        repeat (16) @(negedge clk_i);
        chk({bus_grant_ack_o, bus_oe_o, address_strobe_n_o, lock_n_o, pins[27:25]}, 7'h3c,
            "rst");
        hold_req = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        // all codes against the three driven enable patterns, random address, data and waits
        for (i = 0; i < 21; i++)
        begin
            wait_n = 4'(rnd() % 4);
            send(codes[i % 7], 23'(rnd()), bes[i % 3], i[1] & (codes[i % 7][2:1] == 2'b11),
                1'b0, i[3]);
        end
        req_valid_i = 1'b0;
        wait_until(1'b0, 1'b1);
        // back-to-back traffic with next-address requests
        na_en = 1'b1;
        wait_n = 4'd3;
        for (i = 0; i < 8; i++)
            send({2'b11, i[0]}, 23'(rnd()), CBH_BE_WORD, 1'b0, 1'b0, 1'b0);
        req_valid_i = 1'b0;
        wait_until(1'b0, 1'b1);
        na_en = 1'b0;
        chk(piped > 0, 1, "no overlap");
        // hold raised during a split transfer with slow ready
        wait_n = 4'd6;
        dones = 0;
        send(CBH_CYC_MEM_RD, 23'(rnd()), CBH_BE_WORD, 1'b0, 1'b1, 1'b0);
        hold_req = 1'b1;
        send(CBH_CYC_MEM_WR, 23'(rnd()), CBH_BE_WORD, 1'b0, 1'b0, 1'b0);
        req_valid_i = 1'b0;
        wait_until(1'b1, 1'b0);
        chk(dones, 2, "hold too early");
        nmis = 0;
        repeat (2)
        begin
            nmi_i = 1'b1;
            repeat (8) @(negedge clk_i);
            nmi_i = 1'b0;
            repeat (8) @(negedge clk_i);
        end
        chk(nmis, 0, "interrupt in hold");
        hold_req = 1'b0;
        wait_until(1'b0, 1'b0);
        chk(bus_oe_o, 1, "bus not back");
        repeat (20) @(negedge clk_i);
        chk(nmis, 1, "interrupt edges");
        send(CBH_CYC_CODE, 23'(rnd()), CBH_BE_WORD, 1'b0, 1'b0, 1'b0);
        req_valid_i = 1'b0;
        wait_until(1'b0, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
